// ---- fsp_pkg.sv ----
package fsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses in the cpu data space
   localparam logic [15:0] FSP_OFS_PTR_LOW = 16'hFFA4;
   localparam logic [15:0] FSP_OFS_PTR_HIGH = 16'hFFA5;
   localparam logic [15:0] FSP_OFS_CMP_HIGH = 16'hFFA6;
   localparam logic [15:0] FSP_OFS_CMP_LOW = 16'hFFA7;
   localparam logic [15:0] FSP_OFS_WRITE_BUF = 16'hFFA8;
   // flash location of the protect byte, read back from its captured copy
   localparam logic [15:0] FSP_OFS_PROTECT = 16'h0081;

   ////////////////////////////////////////////////////////////////////////////
   // field positions and reset values
   localparam int FSP_ADDR_W = 12;
   localparam int FSP_PSEL_LSB = 2;
   localparam int FSP_PSEL_MSB = 6;
   localparam logic [7:0] FSP_CMP_RST = 8'h00;
   localparam logic [7:0] FSP_WBUF_RST = 8'h00;
   localparam logic [7:0] FSP_RD_RST = 8'h00;
   localparam logic [4:0] FSP_PSEL_RST = 5'h00;
   localparam logic [4:0] FSP_PSEL_FREE = 5'h1F;
   // code prefixes of the listed protect-select codes
   localparam logic [1:0] FSP_SEL16_TAG = 2'h1;
   localparam logic [2:0] FSP_SEL8_TAG = 3'h3;
   localparam int FSP_BLOCKS_DEF = 16;

   ////////////////////////////////////////////////////////////////////////////
   // commands, states and state records
   typedef enum logic [2:0] {
      FSP_CMD_NONE = 3'h0,
      FSP_CMD_VERIFY1 = 3'h1,
      FSP_CMD_VERIFY2 = 3'h2,
      FSP_CMD_ERASE = 3'h3,
      FSP_CMD_BLANK = 3'h4,
      FSP_CMD_WRITE = 3'h5
   } fsp_cmd_e;

   typedef enum logic [1:0] {
      FSP_IDLE = 2'b01,
      FSP_RUN = 2'b10
   } fsp_phase_e;

   typedef struct packed {
      fsp_phase_e phase;
      fsp_cmd_e cmd;
      logic [7:0] ptrLow;
      logic [7:0] ptrHigh;
      logic [7:0] cmpHigh;
      logic [7:0] cmpLow;
      logic [7:0] writeBuffer;
      logic [4:0] protectSelect;
      logic protLoaded;
      logic [FSP_ADDR_W-1:0] flashAddr;
      logic [7:0] flashData;
      logic flashReq;
      logic busy;
      logic cmdDone;
      logic protViol;
      logic [7:0] rdData;
   } fsp_state_s;

   typedef struct packed {
      logic protAny;
      logic [3:0] protTop;
   } fsp_dec_s;

endpackage

// ---- fsp_protect_dec.sv ----
`timescale 1ns/1ps
module fsp_protect_dec import fsp_pkg::*; #(
   parameter int NUM_BLOCKS = FSP_BLOCKS_DEF
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [4:0] protectSelect,
   output logic protAny,
   output logic [3:0] protTop
);

   fsp_dec_s dec_reg;
   fsp_dec_s dec_next;

   generate
      if (NUM_BLOCKS != 8 && NUM_BLOCKS != 16) begin : g_bad
         $error("fsp_protect_dec: NUM_BLOCKS must be 8 or 16");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // unlisted codes protect everything: a bad byte must not open the boot area
   function automatic fsp_dec_s decode(input logic [4:0] sel);
      fsp_dec_s d;
      // every block number the pointer can name, so an eight-block part refuses too
      d.protAny = 1'b1;
      d.protTop = 4'hF;
      if (sel == FSP_PSEL_FREE) begin
         d.protAny = 1'b0;
         d.protTop = 4'h0;
      end else if (NUM_BLOCKS == 16 && sel[4:3] == FSP_SEL16_TAG) begin
         d.protTop = 4'hF - {sel[2:0], 1'b0};
      end else if (NUM_BLOCKS == 8 && sel[4:2] == FSP_SEL8_TAG) begin
         d.protTop = 4'h7 - {1'b0, sel[1:0], 1'b0};
      end
      return d;
   endfunction

   // decode registered so the compare in the sequencer sees a flop
   always_comb begin
      dec_next = decode(protectSelect);
      if (rst) begin
         dec_next.protAny = 1'b1;
         dec_next.protTop = 4'hF;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || ce) begin
         dec_reg <= dec_next;
      end
   end

   assign protAny = dec_reg.protAny;
   assign protTop = dec_reg.protTop;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !ce);

   a_free_code: assert property (protectSelect == FSP_PSEL_FREE |=> !protAny)
      else $error("free code still protects");
   a_low_pair: assert property (protectSelect == 5'h0F |=> protAny && protTop == 4'h1)
      else $error("code 0F does not protect blocks 1 to 0");

endmodule

// ---- fsp_addr_protect.sv ----
`timescale 1ns/1ps
module fsp_addr_protect import fsp_pkg::*; #(
   parameter int NUM_BLOCKS = FSP_BLOCKS_DEF
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [15:0] cpuAddr,
   input wire logic cpuWr,
   input wire logic cpuBitOp,
   input wire logic [2:0] cpuBitSel,
   input wire logic [7:0] cpuWrData,
   input wire logic cpuRd,
   output logic [7:0] cpuRdData,
   input wire logic [7:0] protByteIn,
   input wire logic selfProgMode,
   input wire logic cmdStart,
   input wire logic [2:0] cmdCode,
   input wire logic flashAck,
   output logic [FSP_ADDR_W-1:0] flashAddr,
   output logic [7:0] flashData,
   output logic [2:0] flashCmd,
   output logic flashReq,
   output logic busy,
   output logic cmdDone,
   output logic protViolation
);

   fsp_state_s st_reg;
   fsp_state_s st_next;
   logic protAny;
   logic [3:0] protTop;
   logic targetProt;
   logic badCode;
   logic [15:0] ptrWord;
   logic [15:0] ptrInc;
   logic atEnd;

   ////////////////////////////////////////////////////////////////////////////
   // protect-select decoder
   fsp_protect_dec #(
      .NUM_BLOCKS(NUM_BLOCKS)
   ) u_dec (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .protectSelect(st_reg.protectSelect),
      .protAny(protAny),
      .protTop(protTop)
   );

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // one bit or a whole byte, as the cpu's bit and byte instructions do
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] d,
                                        input logic bitOp,
                                        input logic [2:0] sel);
      logic [7:0] r;
      r = d;
      if (bitOp) begin
         r = old;
         r[sel] = d[0];
      end
      return r;
   endfunction

   // sequencer address: low nibble of the high pointer above the low byte
   function automatic logic [FSP_ADDR_W-1:0] flatAddr(input logic [15:0] w);
      return {w[11:8], w[7:0]};
   endfunction

   // register writes are only taken while the sequencer is idle
   function automatic logic regHit(input logic [15:0] a,
                                   input logic [15:0] ofs,
                                   input logic en);
      return en && a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command checks
   assign ptrWord = {st_reg.ptrHigh, st_reg.ptrLow};
   assign ptrInc = ptrWord + 16'h0001;
   assign atEnd = ptrWord == {st_reg.cmpHigh, st_reg.cmpLow};

   // erase and write into a protected block are stopped, only in self mode
   assign targetProt = selfProgMode && protAny &&
                       (cmdCode == FSP_CMD_ERASE || cmdCode == FSP_CMD_WRITE) &&
                       st_reg.ptrHigh[3:0] <= protTop;

   // codes outside the command set are refused like a protect error
   assign badCode = cmdCode == FSP_CMD_NONE || cmdCode > FSP_CMD_WRITE;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      logic wrOk;
      wrOk = cpuWr && st_reg.phase == FSP_IDLE && !cmdStart;
      st_next = st_reg;
      st_next.cmdDone = 1'b0;
      st_next.protViol = 1'b0;

      // register writes, bit or byte
      if (regHit(cpuAddr, FSP_OFS_PTR_LOW, wrOk)) begin
         st_next.ptrLow = merge(st_reg.ptrLow, cpuWrData, cpuBitOp, cpuBitSel);
      end
      if (regHit(cpuAddr, FSP_OFS_PTR_HIGH, wrOk)) begin
         st_next.ptrHigh = merge(st_reg.ptrHigh, cpuWrData, cpuBitOp, cpuBitSel);
      end
      if (regHit(cpuAddr, FSP_OFS_CMP_HIGH, wrOk)) begin
         st_next.cmpHigh = merge(st_reg.cmpHigh, cpuWrData, cpuBitOp, cpuBitSel);
      end
      if (regHit(cpuAddr, FSP_OFS_CMP_LOW, wrOk)) begin
         st_next.cmpLow = merge(st_reg.cmpLow, cpuWrData, cpuBitOp, cpuBitSel);
      end
      if (regHit(cpuAddr, FSP_OFS_WRITE_BUF, wrOk)) begin
         st_next.writeBuffer = merge(st_reg.writeBuffer, cpuWrData, cpuBitOp, cpuBitSel);
      end

      // read data is captured, so reads show live pointer counts
      if (cpuRd) begin
         case (cpuAddr)
            FSP_OFS_PTR_LOW: st_next.rdData = st_reg.ptrLow;
            FSP_OFS_PTR_HIGH: st_next.rdData = st_reg.ptrHigh;
            FSP_OFS_CMP_HIGH: st_next.rdData = st_reg.cmpHigh;
            FSP_OFS_CMP_LOW: st_next.rdData = st_reg.cmpLow;
            FSP_OFS_WRITE_BUF: st_next.rdData = st_reg.writeBuffer;
            FSP_OFS_PROTECT: st_next.rdData = {1'b1, st_reg.protectSelect, 2'b11};
            default: st_next.rdData = FSP_RD_RST;
         endcase
      end

      // protect byte caught once, on the first enabled edge after reset
      if (!st_reg.protLoaded) begin
         st_next.protectSelect = protByteIn[FSP_PSEL_MSB:FSP_PSEL_LSB];
         st_next.protLoaded = 1'b1;
      end

      // sequencer
      case (st_reg.phase)
         FSP_IDLE: begin
            if (cmdStart) begin
               if (targetProt || badCode) begin
                  st_next.protViol = 1'b1;
                  st_next.cmdDone = 1'b1;
               end else begin
                  st_next.phase = FSP_RUN;
                  st_next.cmd = fsp_cmd_e'(cmdCode);
                  st_next.flashAddr = flatAddr(ptrWord);
                  st_next.flashData = st_reg.writeBuffer;
                  st_next.flashReq = 1'b1;
                  st_next.busy = 1'b1;
               end
            end
         end
         FSP_RUN: begin
            if (flashAck) begin
               if (st_reg.cmd == FSP_CMD_WRITE || atEnd) begin
                  // pointers keep the last address; software must reload
                  st_next.phase = FSP_IDLE;
                  st_next.flashReq = 1'b0;
                  st_next.busy = 1'b0;
                  st_next.cmdDone = 1'b1;
               end else begin
                  st_next.ptrHigh = ptrInc[15:8];
                  st_next.ptrLow = ptrInc[7:0];
                  st_next.flashAddr = flatAddr(ptrInc);
               end
            end
         end
         default: begin
            st_next.phase = FSP_IDLE;
            st_next.flashReq = 1'b0;
            st_next.busy = 1'b0;
         end
      endcase

      // pointers deliberately left out: they come up undefined
      if (rst) begin
         st_next.phase = FSP_IDLE;
         st_next.cmd = FSP_CMD_NONE;
         st_next.cmpHigh = FSP_CMP_RST;
         st_next.cmpLow = FSP_CMP_RST;
         st_next.writeBuffer = FSP_WBUF_RST;
         st_next.protectSelect = FSP_PSEL_RST;
         st_next.protLoaded = 1'b0;
         st_next.flashAddr = '0;
         st_next.flashData = FSP_WBUF_RST;
         st_next.flashReq = 1'b0;
         st_next.busy = 1'b0;
         st_next.cmdDone = 1'b0;
         st_next.protViol = 1'b0;
         st_next.rdData = FSP_RD_RST;
         st_next.ptrLow = st_reg.ptrLow;
         st_next.ptrHigh = st_reg.ptrHigh;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset acts even while the enable is low
   always_ff @(posedge core_clk) begin
      if (rst || ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign cpuRdData = st_reg.rdData;
   assign flashAddr = st_reg.flashAddr;
   assign flashData = st_reg.flashData;
   assign flashCmd = st_reg.cmd;
   assign flashReq = st_reg.flashReq;
   assign busy = st_reg.busy;
   assign cmdDone = st_reg.cmdDone;
   assign protViolation = st_reg.protViol;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !ce);

   a_cmp_reset: assert property ($past(rst) |-> st_reg.cmpHigh == 8'h00 && st_reg.cmpLow == 8'h00)
      else $error("compare registers not cleared by reset");
   a_wbuf_reset: assert property ($past(rst) |-> st_reg.writeBuffer == 8'h00)
      else $error("write buffer not cleared by reset");
   a_byte_write: assert property (cpuWr && !cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_WRITE_BUF
                                  |=> st_reg.writeBuffer == $past(cpuWrData))
      else $error("byte write to write buffer lost");
   a_bit_write: assert property (cpuWr && cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_CMP_LOW
                                 |=> st_reg.cmpLow[$past(cpuBitSel)] == $past(cpuWrData[0]))
      else $error("bit write to low compare lost");
   a_start_addr: assert property (cmdStart && !busy && !targetProt && !badCode
                                  |=> flashReq && flashAddr == {$past(st_reg.ptrHigh[3:0]), $past(st_reg.ptrLow)})
      else $error("start address not taken from pointers");
   a_ptr_count: assert property (busy && flashAck && !atEnd && flashCmd != FSP_CMD_WRITE
                                 |=> ptrWord == $past(ptrWord) + 16'h0001 && busy)
      else $error("pointer did not count up");
   a_range_end: assert property (busy && flashAck && atEnd |=> cmdDone && !busy && !flashReq)
      else $error("sequencer ran past compare value");
   a_prot_block: assert property (cmdStart && !busy && targetProt
                                  |=> protViolation && cmdDone && !flashReq)
      else $error("protected block was not refused");
   a_mode_gate: assert property (cmdStart && !busy && !selfProgMode && !badCode |=> !protViolation)
      else $error("protection applied outside self mode");
   a_write_data: assert property (flashReq && flashCmd == FSP_CMD_WRITE |-> flashData == st_reg.writeBuffer)
      else $error("write data differs from buffer");

   // register bus: byte and bit writes land, refused writes leave no trace
   a_ptr_byte: assert property (cpuWr && !cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_PTR_HIGH
         |=> st_reg.ptrHigh == $past(cpuWrData))
      else $error("byte write to high pointer lost");
   a_cmp_byte: assert property (cpuWr && !cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_CMP_HIGH
         |=> st_reg.cmpHigh == $past(cpuWrData))
      else $error("byte write to high compare lost");
   a_ptr_bit: assert property (cpuWr && cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_PTR_LOW
         |=> st_reg.ptrLow[$past(cpuBitSel)] == $past(cpuWrData[0]))
      else $error("bit write to low pointer lost");
   a_wbuf_bit: assert property (cpuWr && cpuBitOp && !cmdStart && !busy && cpuAddr == FSP_OFS_WRITE_BUF
         |=> st_reg.writeBuffer[$past(cpuBitSel)] == $past(cpuWrData[0]))
      else $error("bit write to write buffer lost");
   a_start_drop: assert property (cpuWr && cmdStart && cpuAddr == FSP_OFS_CMP_LOW
         |=> st_reg.cmpLow == $past(st_reg.cmpLow))
      else $error("write beside a command start was taken");
   a_busy_drop: assert property (busy && cpuWr && cpuAddr == FSP_OFS_WRITE_BUF
         |=> st_reg.writeBuffer == $past(st_reg.writeBuffer))
      else $error("write buffer changed while busy");

   // read-back and the protect byte copy
   a_rd_back: assert property (cpuRd && cpuAddr == FSP_OFS_CMP_HIGH
         |=> cpuRdData == $past(st_reg.cmpHigh))
      else $error("high compare read back wrong");
   a_prot_read: assert property (cpuRd && cpuAddr == FSP_OFS_PROTECT
         |=> cpuRdData[7] && cpuRdData[1:0] == 2'b11)
      else $error("fixed bits of protect byte wrong");
   a_prot_load: assert property ($past(rst)
         |=> st_reg.protectSelect == $past(protByteIn[FSP_PSEL_MSB:FSP_PSEL_LSB]))
      else $error("protect select not captured after reset");

   // sequencer: what a start latches and how a run ends
   a_cmd_latch: assert property (cmdStart && !busy && !targetProt && !badCode
         |=> busy && flashCmd == $past(cmdCode))
      else $error("command not latched at start");
   a_start_data: assert property (cmdStart && !busy && !targetProt && !badCode
         |=> flashData == $past(st_reg.writeBuffer))
      else $error("write data not copied at start");
   a_req_busy: assert property (flashReq
         |-> busy && flashCmd != FSP_CMD_NONE)
      else $error("request without a latched command");
   a_run_hold: assert property (busy && !flashAck
         |=> busy && flashAddr == $past(flashAddr))
      else $error("address moved without an acknowledge");
   a_end_match: assert property ($past(busy) && cmdDone && flashCmd != FSP_CMD_WRITE
         |-> atEnd)
      else $error("run ended before pointers reached compare");
   a_write_one: assert property (busy && flashAck && flashCmd == FSP_CMD_WRITE
         |=> cmdDone && !busy && ptrWord == $past(ptrWord))
      else $error("byte write did not end after one address");

   // protection and the one-cycle status pulses
   a_verify_free: assert property (cmdStart && !busy && !badCode && cmdCode != FSP_CMD_ERASE
         && cmdCode != FSP_CMD_WRITE |=> busy && !protViolation)
      else $error("verify or blank check was refused");
   a_free_open: assert property (cmdStart && !busy && !badCode && !protAny
         |=> busy && !protViolation)
      else $error("free code still refused a command");
   a_mode_free: assert property (cmdStart && !busy && !selfProgMode && !badCode
         |=> busy)
      else $error("command refused outside self mode");
   a_bad_code: assert property (cmdStart && !busy && badCode
         |=> protViolation && cmdDone && !busy)
      else $error("unknown command code not refused");
   a_viol_pulse: assert property (protViolation && !cmdStart
         |=> !protViolation)
      else $error("violation pulse longer than one cycle");
   a_done_pulse: assert property (cmdDone && !cmdStart
         |=> !cmdDone)
      else $error("done pulse longer than one cycle");

   c_erase_run: cover property (cmdStart && cmdCode == FSP_CMD_ERASE && !targetProt ##1 busy ##[1:20] cmdDone);
   c_verify_walk: cover property (busy && flashAck && !atEnd ##1 busy && flashAck && !atEnd);
   c_prot_hit: cover property (cmdStart && targetProt ##1 protViolation);
   c_byte_write: cover property (busy && flashCmd == FSP_CMD_WRITE && flashAck ##1 cmdDone);
   c_bad_code: cover property (cmdStart && badCode ##1 protViolation);

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module testbench import fsp_pkg::*; ;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [15:0] cpuAddr = 16'h0000;
   logic cpuWr = 1'b0;
   logic cpuBitOp = 1'b0;
   logic [2:0] cpuBitSel = 3'h0;
   logic [7:0] cpuWrData = 8'h00;
   logic cpuRd = 1'b0;
   logic [7:0] protByteIn = 8'hFF;
   logic selfProgMode = 1'b0;
   logic cmdStart = 1'b0;
   logic [2:0] cmdCode = 3'h0;
   logic flashAck = 1'b0;
   logic [7:0] cpuRdData;
   logic [FSP_ADDR_W-1:0] flashAddr;
   logic [7:0] flashData;
   logic [2:0] flashCmd;
   logic flashReq, busy, cmdDone, protViolation, violation8;
   logic [7:0] wbufExp = 8'h00;
   int errors = 0;
   int samplesChecked = 0;

   ////////////////////////////////////////////////////////////////////////////
   // clock, then a sixteen- and an eight-block part sharing every input
   always #12.5 core_clk = ~core_clk;

   fsp_addr_protect #(.NUM_BLOCKS(16)) dut (.core_clk(core_clk), .rst(rst), .ce(ce), .cpuAddr(cpuAddr),
      .cpuWr(cpuWr), .cpuBitOp(cpuBitOp), .cpuBitSel(cpuBitSel), .cpuWrData(cpuWrData), .cpuRd(cpuRd),
      .cpuRdData(cpuRdData), .protByteIn(protByteIn), .selfProgMode(selfProgMode), .cmdStart(cmdStart),
      .cmdCode(cmdCode), .flashAck(flashAck), .flashAddr(flashAddr), .flashData(flashData),
      .flashCmd(flashCmd), .flashReq(flashReq), .busy(busy), .cmdDone(cmdDone), .protViolation(protViolation));
   // eight-block part only ever protects as much or more, so it never runs while the other refuses
   fsp_addr_protect #(.NUM_BLOCKS(8)) dut8 (.core_clk(core_clk), .rst(rst), .ce(ce), .cpuAddr(cpuAddr),
      .cpuWr(cpuWr), .cpuBitOp(cpuBitOp), .cpuBitSel(cpuBitSel), .cpuWrData(cpuWrData), .cpuRd(cpuRd),
      .cpuRdData(), .protByteIn(protByteIn), .selfProgMode(selfProgMode), .cmdStart(cmdStart),
      .cmdCode(cmdCode), .flashAck(flashAck), .flashAddr(), .flashData(), .flashCmd(), .flashReq(),
      .busy(), .cmdDone(), .protViolation(violation8));

   ////////////////////////////////////////////////////////////////////////////
   // bus helpers; all start and end just after a falling edge
   task automatic do_reset(input logic [7:0] pb, input int n);
      protByteIn = pb;
      rst = 1'b1;
      repeat (n) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bitOp = 1'b0,
                     input logic [2:0] sel = 3'h0);
      cpuAddr = a;
      cpuWrData = d;
      cpuBitOp = bitOp;
      cpuBitSel = sel;
      cpuWr = 1'b1;
      @(negedge core_clk);
      cpuWr = 1'b0;
      cpuBitOp = 1'b0;
      // idle cycle so a following call never retoggles the strobe in one step
      @(negedge core_clk);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string nm);
      cpuAddr = a;
      cpuRd = 1'b1;
      @(negedge core_clk);
      cpuRd = 1'b0;
      `CHK(nm, exp, cpuRdData)
      @(negedge core_clk);
   endtask

   // loads pointers and compares, starts a command and plays the flash side
   task automatic run(input logic [2:0] code, input logic [15:0] p, input logic [15:0] c,
                      input logic refuse, input logic refuse8);
      int n;
      n = (code == 3'h5) ? 1 : int'(c - p) + 1;
      wr(FSP_OFS_PTR_HIGH, p[15:8]);
      wr(FSP_OFS_PTR_LOW, p[7:0]);
      wr(FSP_OFS_CMP_HIGH, c[15:8]);
      wr(FSP_OFS_CMP_LOW, c[7:0]);
      cmdCode = code;
      cmdStart = 1'b1;
      @(negedge core_clk);
      cmdStart = 1'b0;
      `CHK("protViolation", refuse, protViolation)
      `CHK("violation8", refuse8, violation8)
      if (refuse) begin
         `CHK("refusedDone", 1'b1, cmdDone)
         `CHK("refusedBusy", 1'b0, busy)
         @(negedge core_clk);
         `CHK("violationPulse", 1'b0, protViolation)
      end else begin
         `CHK("flashCmd", code, flashCmd)
         if (code == 3'h5) `CHK("flashData", wbufExp, flashData)
         for (int i = 0; i < n; i++) begin
            `CHK("flashAddr", p[11:0] + 12'(i), flashAddr)
            `CHK("flashReq", 1'b1, flashReq)
            flashAck = 1'b1;
            @(negedge core_clk);
         end
         flashAck = 1'b0;
         `CHK("cmdDone", 1'b1, cmdDone)
         `CHK("busyEnd", 1'b0, busy)
         @(negedge core_clk);
         rd_chk(FSP_OFS_PTR_LOW, (code == 3'h5) ? p[7:0] : c[7:0], "ptrEnd");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs;
      rd_chk(FSP_OFS_CMP_HIGH, FSP_CMP_RST, "cmpHighRst");
      rd_chk(FSP_OFS_CMP_LOW, FSP_CMP_RST, "cmpLowRst");
      rd_chk(FSP_OFS_WRITE_BUF, FSP_WBUF_RST, "wbufRst");
      rd_chk(16'hFFA9, 8'h00, "unmapped");
      rd_chk(FSP_OFS_PROTECT, 8'hFF, "protByte");
      wr(FSP_OFS_PTR_HIGH, 8'h0B);
      wr(FSP_OFS_PTR_LOW, 8'hC4);
      wr(FSP_OFS_CMP_HIGH, 8'h0D);
      wr(FSP_OFS_CMP_LOW, 8'h96);
      wr(FSP_OFS_WRITE_BUF, 8'h5A);
      rd_chk(FSP_OFS_PTR_HIGH, 8'h0B, "ptrHigh");
      rd_chk(FSP_OFS_PTR_LOW, 8'hC4, "ptrLow");
      rd_chk(FSP_OFS_CMP_HIGH, 8'h0D, "cmpHigh");
      rd_chk(FSP_OFS_CMP_LOW, 8'h96, "cmpLow");
      wr(FSP_OFS_WRITE_BUF, 8'h01, 1'b1, 3'h7);
      wr(FSP_OFS_WRITE_BUF, 8'h00, 1'b1, 3'h1);
      rd_chk(FSP_OFS_WRITE_BUF, 8'hD8, "wbufBits");
      wr(FSP_OFS_PTR_LOW, 8'h01, 1'b1, 3'h0);
      rd_chk(FSP_OFS_PTR_LOW, 8'hC5, "ptrLowBit");
      $display("test t_regs done");
   endtask

   task automatic t_cmds;
      logic [2:0] badCodes [3] = '{3'h0, 3'h6, 3'h7};
      run(FSP_CMD_VERIFY1, 16'h0300, 16'h0301, 1'b0, 1'b0);
      run(FSP_CMD_VERIFY2, 16'h0A10, 16'h0A13, 1'b0, 1'b0);
      run(FSP_CMD_BLANK, 16'h0200, 16'h02FF, 1'b0, 1'b0);
      run(FSP_CMD_ERASE, 16'h0F00, 16'h0F00, 1'b0, 1'b0);
      wbufExp = 8'h3C;
      wr(FSP_OFS_WRITE_BUF, wbufExp);
      run(FSP_CMD_WRITE, 16'h0712, 16'h0712, 1'b0, 1'b0);
      // unknown command codes come back refused
      foreach (badCodes[k]) run(badCodes[k], 16'h0400, 16'h0400, 1'b1, 1'b1);
      $display("test t_cmds done");
   endtask

   task automatic t_protect;
      logic [4:0] code;
      logic [3:0] top;
      // every reset below clears the buffer that the write runs carry
      wbufExp = FSP_WBUF_RST;
      for (int k = 0; k < 8; k++) begin
         code = 5'h08 + 5'(k);
         top = 4'(15 - 2 * k);
         do_reset({1'b1, code, 2'b11}, 2);
         rd_chk(FSP_OFS_PROTECT, {1'b1, code, 2'b11}, "protByte");
         selfProgMode = 1'b1;
         run(FSP_CMD_ERASE, {4'h0, top, 8'h00}, {4'h0, top, 8'h00}, 1'b1, 1'b1);
         if (top != 4'hF) run(FSP_CMD_ERASE, {4'h0, top + 4'h1, 8'h00}, {4'h0, top + 4'h1, 8'h00}, 1'b0, k < 4);
         run(FSP_CMD_VERIFY1, {4'h0, top, 8'h10}, {4'h0, top, 8'h11}, 1'b0, 1'b0);
         selfProgMode = 1'b0;
         run(FSP_CMD_WRITE, {4'h0, top, 8'h20}, {4'h0, top, 8'h20}, 1'b0, 1'b0);
      end
      do_reset({1'b1, FSP_PSEL_FREE, 2'b11}, 2);
      selfProgMode = 1'b1;
      run(FSP_CMD_ERASE, 16'h0000, 16'h0000, 1'b0, 1'b0);
      do_reset(8'h83, 2);
      run(FSP_CMD_WRITE, 16'h0F30, 16'h0F30, 1'b1, 1'b1);
      $display("test t_protect done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the watchdog
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      do_reset(8'hFF, 16);
      t_regs();
      t_cmds();
      t_protect();
      close_out();
   end

   // the whole run needs just under nine hundred cycles, so this only cuts a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      close_out();
   end
endmodule
